//--- src/pss_consts.vh
// Constants for the port S pin control block: offsets, fields, resets, timing.
// Included by the pin control block, its bench and its checker; holds definitions only.
`ifndef PSS_CONSTS_VH
`define PSS_CONSTS_VH

// Printed offsets are not all multiples of four: indices, byte address = 4*index
`define PSS_IDX_OUTPUT_VALUE  12'h248
`define PSS_IDX_PIN_LEVEL     12'h249
`define PSS_IDX_DIRECTION     12'h24a
`define PSS_IDX_ROUTE         12'h24b
`define PSS_ADDR_W            14

// Fields of the route/mode register
`define PSS_RT_SPI            0
`define PSS_RT_TWI            1
`define PSS_RT_PC0            2
`define PSS_RT_PC1            3
`define PSS_RT_PC2            4
`define PSS_RT_PC3            5
`define PSS_RT_PC6            6
`define PSS_RT_PC7            7
`define PSS_RT_PC7_SHDN       8
`define PSS_RT_W              9

// Reset values
`define PSS_RST_OUTPUT_VALUE  8'h00
`define PSS_RST_DIRECTION     8'h00
`define PSS_RST_ROUTE         9'h000

// Pin input synchroniser depth, two agreeing stages after the first
`define PSS_SYNC_STAGES       3

`endif

//--- src/pss_gpio.v
// Port S general-purpose pin control: data, input-level and direction registers
// with alternate-function override of direction and output value.
// Assumes an APB master on i_mclk and pin pads resolved outside (oe active low).
//
// What this block does
// RULE1: Pin 1: serial tx, then channel 7, then GPIO
// RULE2: Pin 0: serial rx, then channel 6, then GPIO
// RULE3: GPIO output drives stored data bit
// RULE4: Data read: stored bit if output, else pin
// RULE5: Level register reads all synced pins always
// RULE6: Level register ignores writes, mirrors pins
// RULE7: Direction bit 1 output, 0 input
// RULE8: Pin 7: SPI, then open-drain two-wire, then channel 3
// RULE9: Pin 6: SPI, then channel 2 output
// RULE10: Pin 5: SPI, then channel 1 output
// RULE11: Pin 4: SPI, then open-drain two-wire, then channel 0
// RULE12: Pin 1: serial output, channel 7 output or shutdown input
// RULE13: Pin 0: serial input, channel 6 output
// RULE14: Reads settle five clocks after direction change
// RULE15: Data register kept while alternate function owns pin
`timescale 1ns/1ps
`include "pss_consts.vh"

module pss_gpio (
  // Clock, reset, enable
  input  wire        i_mclk,
  input  wire        i_rst,
  input  wire        i_ce,
  // APB slave
  input  wire        i_psel,
  input  wire        i_penable,
  input  wire        i_pwrite,
  input  wire [15:0] i_paddr,
  input  wire [31:0] i_pwdata,
  output wire        o_pready,
  output wire        o_pslverr,
  output reg  [31:0] o_prdata,
  // Alternate function enables
  input  wire        i_async_serial_unit_tx_en,
  input  wire        i_async_serial_unit_rx_en,
  input  wire        i_spi_en,
  input  wire        i_two_wire_unit_en,
  input  wire [7:0]  i_pulse_channel_en,
  // Alternate function output data and SPI direction
  input  wire        i_async_serial_unit_txd,
  input  wire [7:0]  i_pulse_channel_out,
  input  wire [3:0]  i_spi_out,
  input  wire [3:0]  i_spi_dir_out,
  input  wire        i_two_wire_unit_sda_low,
  input  wire        i_two_wire_unit_scl_low,
  // Pins
  input  wire [7:0]  i_port_s_pins,
  output reg  [7:0]  o_port_s_pins,
  output reg  [7:0]  o_port_s_pins_oe_n,
  output wire [7:0]  o_port_s_pin_level
);

  reg  [7:0]          port_s_output_value_r;
  reg  [7:0]          port_s_direction_r;
  reg  [`PSS_RT_W-1:0] route_r;
  wire [7:0]          pin_sync;
  reg  [7:0]          eff_dir;
  reg  [7:0]          eff_out;
  reg  [7:0]          read_mux;

  wire                acc     = i_psel & i_penable;
  wire                wr      = acc & i_pwrite & i_ce;
  wire [13:0]         idx     = i_paddr[15:2];
  wire                hit_out = (idx == `PSS_IDX_OUTPUT_VALUE);
  wire                hit_lvl = (idx == `PSS_IDX_PIN_LEVEL);
  wire                hit_dir = (idx == `PSS_IDX_DIRECTION);
  wire                hit_rt  = (idx == `PSS_IDX_ROUTE);
  wire                mapped  = hit_out | hit_lvl | hit_dir | hit_rt;
  wire                bad_al  = (i_paddr[1:0] != 2'b00);

  // Zero-wait slave; frozen clock enable stalls the access phase
  assign o_pready  = i_ce;
  assign o_pslverr = acc & (~mapped | bad_al);

  genvar g;
  generate
    for (g = 0; g < 8; g = g + 1) begin : g_sync
      pss_pin_sync u_sync (
        .i_mclk  (i_mclk),
        .i_rst   (i_rst),
        .i_ce    (i_ce),
        .i_pin   (i_port_s_pins[g]),
        .o_level (pin_sync[g])
      );
    end
  endgenerate

  // Synchroniser latency covers the settling window on reads
  assign o_port_s_pin_level = pin_sync; // RULE14

  // Software writes; data register always writable, even under alternate control
  always @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      port_s_output_value_r <= `PSS_RST_OUTPUT_VALUE;
      port_s_direction_r    <= `PSS_RST_DIRECTION;
      route_r               <= `PSS_RST_ROUTE;
    end else if (wr && !bad_al) begin
      if (hit_out) begin
        port_s_output_value_r <= i_pwdata[7:0]; // RULE15
      end
      if (hit_dir) begin
        port_s_direction_r <= i_pwdata[7:0];
      end
      if (hit_rt) begin
        route_r <= i_pwdata[`PSS_RT_W-1:0];
      end
      // Writes to the level register fall through with no effect
    end
  end

  // Effective direction and output per pin, by priority
  always @* begin
    eff_dir = port_s_direction_r; // RULE7
    eff_out = port_s_output_value_r; // RULE3
    // Pin 7
    if (i_spi_en && route_r[`PSS_RT_SPI]) begin // RULE8
      eff_dir[7] = i_spi_dir_out[3];
      eff_out[7] = i_spi_out[3];
    end else if (i_two_wire_unit_en && route_r[`PSS_RT_TWI]) begin
      eff_dir[7] = i_two_wire_unit_sda_low;
      eff_out[7] = 1'b0;
    end else if (i_pulse_channel_en[3] && route_r[`PSS_RT_PC3]) begin
      eff_dir[7] = 1'b1;
      eff_out[7] = i_pulse_channel_out[3];
    end
    // Pin 6
    if (i_spi_en && route_r[`PSS_RT_SPI]) begin // RULE9
      eff_dir[6] = i_spi_dir_out[2];
      eff_out[6] = i_spi_out[2];
    end else if (i_pulse_channel_en[2] && route_r[`PSS_RT_PC2]) begin
      eff_dir[6] = 1'b1;
      eff_out[6] = i_pulse_channel_out[2];
    end
    // Pin 5
    if (i_spi_en && route_r[`PSS_RT_SPI]) begin // RULE10
      eff_dir[5] = i_spi_dir_out[1];
      eff_out[5] = i_spi_out[1];
    end else if (i_pulse_channel_en[1] && route_r[`PSS_RT_PC1]) begin
      eff_dir[5] = 1'b1;
      eff_out[5] = i_pulse_channel_out[1];
    end
    // Pin 4
    if (i_spi_en && route_r[`PSS_RT_SPI]) begin // RULE11
      eff_dir[4] = i_spi_dir_out[0];
      eff_out[4] = i_spi_out[0];
    end else if (i_two_wire_unit_en && route_r[`PSS_RT_TWI]) begin
      eff_dir[4] = i_two_wire_unit_scl_low;
      eff_out[4] = 1'b0;
    end else if (i_pulse_channel_en[0] && route_r[`PSS_RT_PC0]) begin
      eff_dir[4] = 1'b1;
      eff_out[4] = i_pulse_channel_out[0];
    end
    // Pin 1
    if (i_async_serial_unit_tx_en) begin // RULE1
      eff_dir[1] = 1'b1; // RULE12
      eff_out[1] = i_async_serial_unit_txd;
    end else if (i_pulse_channel_en[7] && route_r[`PSS_RT_PC7]) begin
      eff_dir[1] = ~route_r[`PSS_RT_PC7_SHDN]; // RULE12
      eff_out[1] = i_pulse_channel_out[7];
    end
    // Pin 0
    if (i_async_serial_unit_rx_en) begin // RULE2
      eff_dir[0] = 1'b0; // RULE13
    end else if (i_pulse_channel_en[6] && route_r[`PSS_RT_PC6]) begin
      eff_dir[0] = 1'b1; // RULE13
      eff_out[0] = i_pulse_channel_out[6];
    end
  end

  // Pads from flops; open-drain two-wire pins drive low only when enabled
  always @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      o_port_s_pins      <= 8'h00;
      o_port_s_pins_oe_n <= 8'hff;
    end else if (i_ce) begin
      o_port_s_pins      <= eff_out;
      o_port_s_pins_oe_n <= ~eff_dir;
    end
  end

  // Read data: direction register chooses stored bit or pin level
  always @* begin
    read_mux = 8'h00;
    if (hit_out) begin
      read_mux = (port_s_output_value_r & port_s_direction_r) | (pin_sync & ~port_s_direction_r); // RULE4
    end else if (hit_lvl) begin
      read_mux = pin_sync; // RULE5
    end else if (hit_dir) begin
      read_mux = port_s_direction_r;
    end
  end

  // Level register is never stored, so writes cannot touch it; reset clears its synchronisers
  always @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      o_prdata <= 32'h0000_0000;
    end else if (i_ce && i_psel && !i_penable && !i_pwrite) begin
      if (hit_rt) begin
        o_prdata <= {{(32-`PSS_RT_W){1'b0}}, route_r};
      end else begin
        o_prdata <= {24'h00_0000, read_mux}; // RULE6
      end
    end
  end

endmodule

//--- src/pss_pin_sync.v
// Per-pin input synchroniser with agreement filter.
// Assumes pins are asynchronous to i_mclk; one instance per pin.
`timescale 1ns/1ps

module pss_pin_sync (
  // Clock and reset
  input  wire i_mclk,
  input  wire i_rst,
  input  wire i_ce,
  // Pin and result
  input  wire i_pin,
  output reg  o_level
);

  reg s1_r;
  reg s2_r;
  reg s3_r;

  // Level holds until stages two and three agree; stage one feeds only stage two
  always @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      s1_r    <= 1'b0;
      s2_r    <= 1'b0;
      s3_r    <= 1'b0;
      o_level <= 1'b0;
    end else if (i_ce) begin
      s1_r <= i_pin;
      s2_r <= s1_r;
      s3_r <= s2_r;
      if (s2_r == s3_r) begin
        o_level <= s3_r;
      end
    end
  end

endmodule

//--- verif/pss_gpio_bench.sv
// Self-checking bench for the port S pin control block.
// Assumes the pin model resolves the pads and i_ce stays high.
`timescale 1ns/1ps
`include "pss_consts.vh"
module pss_gpio_bench;
  localparam logic [15:0] ad_dat = `PSS_IDX_OUTPUT_VALUE << 2;
  localparam logic [15:0] ad_lvl = `PSS_IDX_PIN_LEVEL << 2;
  localparam logic [15:0] ad_dir = `PSS_IDX_DIRECTION << 2;
  localparam logic [15:0] ad_rt  = `PSS_IDX_ROUTE << 2;
  logic        clk = 0, rst = 1, ce = 1, psel = 0, pen = 0, pwr = 0, rdy, err, es;
  logic        txe = 0, rxe = 0, spe = 0, twe = 0, txd = 0, sda = 0, scl = 0;
  logic [15:0] adr = 0;
  logic [31:0] wd = 0, rd, prd;
  logic [7:0]  pce = 0, pco = 0, xv = 0, xe = 0, pad, po, poe, lvl;
  logic [3:0]  so = 0, sd = 0;
  int          bad_count = 0, checks = 0;
  initial forever #5 clk = ~clk;
  pss_gpio i_dut (.i_mclk(clk), .i_rst(rst), .i_ce(ce), .i_psel(psel), .i_penable(pen), .i_pwrite(pwr),
    .i_paddr(adr), .i_pwdata(wd), .o_pready(rdy), .o_pslverr(err), .o_prdata(prd),
    .i_async_serial_unit_tx_en(txe), .i_async_serial_unit_rx_en(rxe), .i_spi_en(spe),
    .i_two_wire_unit_en(twe), .i_pulse_channel_en(pce), .i_async_serial_unit_txd(txd),
    .i_pulse_channel_out(pco), .i_spi_out(so), .i_spi_dir_out(sd), .i_two_wire_unit_sda_low(sda),
    .i_two_wire_unit_scl_low(scl), .i_port_s_pins(pad), .o_port_s_pins(po), .o_port_s_pins_oe_n(poe),
    .o_port_s_pin_level(lvl));
  pss_pin_model i_pins (.i_mclk(clk), .i_out(po), .i_oe_n(poe), .i_ext_val(xv), .i_ext_en(xe), .o_pad(pad));
  task chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      bad_count++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task cyc(input int n);
    repeat (n) @(posedge clk);
  endtask
  // Entered just after an edge; holds the request until pready is seen
  task apb(input logic w, input logic [15:0] a, input logic [31:0] d);
    psel <= 1;
    pwr  <= w;
    adr  <= a;
    wd   <= d;
    @(posedge clk);
    pen <= 1;
    @(posedge clk);
    while (rdy !== 1'b1) @(posedge clk);
    rd = prd;
    es = err;
    psel <= 0;
    pen  <= 0;
    @(posedge clk);
  endtask
  task rdc(input logic [15:0] a, input logic [31:0] e);
    apb(0, a, 0);
    chk(rd, e);
  endtask
  task t_regs;
    rdc(ad_dir, 0);
    rdc(ad_rt, 0);
    apb(0, 16'h0930, 0);
    chk(es, 1);
    apb(0, 16'h0922, 0);
    chk(es, 1);
    $display("t_regs done");
  endtask
  task t_gpio;
    xv <= 8'h3c;
    xe <= 8'hff;
    apb(1, ad_dir, 32'h0f);
    apb(1, ad_dat, 32'ha5);
    cyc(6);
    chk(pad, 8'h35);
    rdc(ad_dat, 32'h35);
    rdc(ad_lvl, 32'h35);
    apb(1, ad_lvl, 32'hff);
    rdc(ad_lvl, 32'h35);
    apb(1, ad_dir, 0);
    cyc(5);
    rdc(ad_dat, 32'h3c);
    $display("t_gpio done");
  endtask
  task t_alt;
    xe <= 0;
    apb(1, ad_dir, 32'hff);
    apb(1, ad_dat, 0);
    apb(1, ad_rt, 32'hc0);
    pce <= 8'hc0;
    pco <= 8'hc0;
    cyc(2);
    chk({poe[1:0], po[1:0]}, 4'h3);
    txe <= 1;
    rxe <= 1;
    apb(1, ad_dat, 32'h03);
    chk({poe[1:0], po[1]}, 3'b010);
    txe <= 0;
    rxe <= 0;
    apb(1, ad_rt, 32'h1c0);
    cyc(2);
    chk({poe[1:0], po[0]}, 3'b101);
    apb(1, ad_rt, 0);
    cyc(2);
    chk(pad[1:0], 2'b11);
    $display("t_alt done");
  endtask
  task t_spi;
    apb(1, ad_dir, 0);
    apb(1, ad_rt, 32'h3f);
    pce <= 8'h0f;
    pco <= 8'h05;
    spe <= 1;
    twe <= 1;
    sd  <= 4'h5;
    so  <= 4'hf;
    sda <= 1;
    cyc(2);
    chk({poe[7:4], po[6], po[4]}, 6'h2b);
    spe <= 0;
    cyc(2);
    chk({poe[7:4], po[7:5]}, 7'h0a);
    twe <= 0;
    cyc(2);
    chk({poe[7:4], po[7:4]}, 8'h05);
    $display("t_spi done");
  endtask
  task results;
    $display("checks=%0d bad_count=%0d", checks, bad_count);
    if (bad_count == 0 && checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  initial begin
    cyc(5);
    rst <= 0;
    cyc(1);
    t_regs;
    t_gpio;
    t_alt;
    t_spi;
    results;
  end
  initial begin
    cyc(3000);
    bad_count++;
    results;
  end
endmodule

//--- verif/pss_gpio_props.sv
// Checker on the port S pin control block's ports.
// Assumes one clock domain and i_ce held high during traffic.
`timescale 1ns/1ps
`include "pss_consts.vh"
module pss_gpio_props (
  // Clock, reset and register bus
  input wire logic        i_mclk,
  input wire logic        i_rst,
  input wire logic        i_psel,
  input wire logic        i_penable,
  input wire logic        i_pwrite,
  input wire logic [15:0] i_paddr,
  input wire logic [31:0] i_pwdata,
  input wire logic        o_pslverr,
  input wire logic        o_pready,
  // Alternate functions and pins
  input wire logic        i_async_serial_unit_tx_en,
  input wire logic        i_async_serial_unit_rx_en,
  input wire logic        i_async_serial_unit_txd,
  input wire logic [7:0]  i_port_s_pins,
  input wire logic [7:0]  o_port_s_pins,
  input wire logic [7:0]  o_port_s_pins_oe_n,
  input wire logic [7:0]  o_port_s_pin_level
);
  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (i_rst);
  wire wr     = i_psel && i_penable && i_pwrite;
  wire wr_dat = wr && i_paddr == {`PSS_IDX_OUTPUT_VALUE, 2'b00};
  wire wr_dir = wr && i_paddr == {`PSS_IDX_DIRECTION, 2'b00};
  wire wr_lvl = wr && i_paddr == {`PSS_IDX_PIN_LEVEL, 2'b00};
  property p_tx;
    i_async_serial_unit_tx_en |=> !o_port_s_pins_oe_n[1] && o_port_s_pins[1] == $past(i_async_serial_unit_txd);
  endproperty
  a_tx: assert property (p_tx) else $error("serial transmit does not own pin 1");
  property p_rx;
    i_async_serial_unit_rx_en |=> o_port_s_pins_oe_n[0];
  endproperty
  a_rx: assert property (p_rx) else $error("serial receive does not release pin 0");
  property p_dat;
    wr_dat |-> ##2 (o_port_s_pins_oe_n[3] || o_port_s_pins[3] == $past(i_pwdata[3], 2));
  endproperty
  a_dat: assert property (p_dat) else $error("stored bit not driven on pin 3");
  property p_dir;
    wr_dir |-> ##2 o_port_s_pins_oe_n[3:2] == ~$past(i_pwdata[3:2], 2);
  endproperty
  a_dir: assert property (p_dir) else $error("direction bits not applied to pins 3 and 2");
  property p_lvl;
    $stable(i_port_s_pins)[*6] |-> o_port_s_pin_level == i_port_s_pins;
  endproperty
  a_lvl: assert property (p_lvl) else $error("pin level does not follow steady pins");
  property p_wlvl;
    wr_lvl |-> !o_pslverr && o_pready;
  endproperty
  a_wlvl: assert property (p_wlvl) else $error("write to pin level register refused");
  property p_unal;
    i_psel && i_penable && i_paddr[1:0] != 2'b00 |-> o_pslverr;
  endproperty
  a_unal: assert property (p_unal) else $error("unaligned access not flagged");
  property p_setup;
    i_psel && !i_penable |-> !o_pslverr;
  endproperty
  a_setup: assert property (p_setup) else $error("error flagged outside access phase");
endmodule
bind pss_gpio pss_gpio_props i_props (.*);

//--- verif/pss_pin_model.sv
// Pads of port S as seen from outside the block.
// Assumes oe_n low means the block drives; an undriven pad wanders every cycle.
`timescale 1ns/1ps
module pss_pin_model (
  // Clock
  input  wire logic       i_mclk,
  // Block side and outside driver
  input  wire logic [7:0] i_out,
  input  wire logic [7:0] i_oe_n,
  input  wire logic [7:0] i_ext_val,
  input  wire logic [7:0] i_ext_en,
  // Resolved pads
  output wire logic [7:0] o_pad
);
  logic [7:0] float_r = 8'h00;
  // No keeper on the pads, so a released pad with no outside driver never holds its last level
  always @(posedge i_mclk) float_r <= ~float_r;
  assign o_pad = (~i_oe_n & i_out) | (i_oe_n & ((i_ext_en & i_ext_val) | (~i_ext_en & float_r)));
endmodule
